// *** rtl/csr_pkg.sv ***
// Operation
// - Register space is upper 128, direct only
// - Instruction counter and banks stay outside space
// - Operand register is ALU source and destination
// - Helper byte joins multiply/divide, else scratch
// - Push increments stack pointer, then writes
// - Stack pointer low resets to 07H
// - Upper register low three bits extend pointer
// - Data pointer is page, high, low bytes
// - Pointer increment carries into page byte
// - Pointer usable as word or three bytes
// - Flags word at D0H, resets 00H, bit addressable
// - Flag bit order carry down to parity
// - Lowest 32 bytes hold four eight-register banks
package csr_pkg;

  // Byte addresses in the register space
  localparam logic [7:0] CSR_ADDR_STACK_LOW   = 8'h81;
  localparam logic [7:0] CSR_ADDR_DATA_POINTER_WORD_LOW    = 8'h82;
  localparam logic [7:0] CSR_ADDR_DATA_POINTER_WORD_HIGH   = 8'h83;
  localparam logic [7:0] CSR_ADDR_DATA_POINTER_WORD_PAGE   = 8'h84;
  localparam logic [7:0] CSR_ADDR_STACK_UPPER = 8'hb7;
  localparam logic [7:0] CSR_ADDR_FLAGS       = 8'hd0;
  localparam logic [7:0] CSR_ADDR_OPERAND     = 8'he0;
  localparam logic [7:0] CSR_ADDR_HELPER      = 8'hf0;

  // Reset values
  localparam logic [7:0] CSR_RST_STACK_LOW   = 8'h07;
  localparam logic [7:0] CSR_RST_STACK_UPPER = 8'h00;
  localparam logic [7:0] CSR_RST_FLAGS       = 8'h00;
  localparam logic [7:0] CSR_RST_DATA_POINTER_WORD        = 8'h00;
  localparam logic [7:0] CSR_RST_OPERAND     = 8'h00;
  localparam logic [7:0] CSR_RST_HELPER      = 8'h00;
  localparam logic [7:0] CSR_RD_UNMAPPED     = 8'h00;

  // Flags word field positions
  localparam int CSR_FLAG_CARRY  = 7;
  localparam int CSR_FLAG_HALF   = 6;
  localparam int CSR_FLAG_USER0  = 5;
  localparam int CSR_FLAG_BANKHI = 4;
  localparam int CSR_FLAG_BANKLO = 3;
  localparam int CSR_FLAG_RANGE  = 2;
  localparam int CSR_FLAG_USER1  = 1;
  localparam int CSR_FLAG_PARITY = 0;

  // Stack pointer geometry
  localparam int CSR_STACK_BITS = 11;
  localparam int CSR_STACK_EXT  = 3;

  // Working register banks
  localparam int CSR_BANK_REGS_LOG2 = 3;
  localparam int CSR_BANK_BASE_BITS = 5;

endpackage : csr_pkg

// *** rtl/csr_core_regs.sv ***
`timescale 1ns/1ps
`default_nettype none

module csr_core_regs
  import csr_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        reset_n,
  // Direct register port from the datapath
  input  wire logic        sfrDirect,
  input  wire logic [7:0]  sfrAddr,
  input  wire logic        sfrWrEn,
  input  wire logic [7:0]  sfrWrData,
  input  wire logic        sfrRdEn,
  output logic      [7:0]  sfrRdData,
  output logic             sfrRdHit,
  // Bit-addressed access
  input  wire logic [7:0]  bitAddr,
  input  wire logic        bitWrEn,
  input  wire logic        bitWrVal,
  input  wire logic        bitRdEn,
  output logic             bitRdVal,
  // Execution results
  input  wire logic        accLoadEn,
  input  wire logic [7:0]  accLoadData,
  input  wire logic        helperLoadEn,
  input  wire logic [7:0]  helperLoadData,
  input  wire logic [7:0]  flagLoadMask,
  input  wire logic [7:0]  flagLoadData,
  // Stack and pointer operations
  input  wire logic        pushEn,
  input  wire logic        popEn,
  input  wire logic        extStackEn,
  input  wire logic        dptrIncEn,
  // Register values towards the datapath
  output logic      [7:0]  mainOperandReg,
  output logic      [7:0]  helperReg,
  output logic      [10:0] stackAddr,
  output logic      [23:0] dataPointerFull,
  output logic      [15:0] dataPointerWord,
  output logic      [1:0]  bankSelect,
  output logic      [4:0]  workRegBase,
  output logic             carryFlag,
  output logic             halfCarryFlag,
  output logic             userFlagZero,
  output logic             arithRangeFlag,
  output logic             userFlagOne,
  output logic             parityFlag
);

  // Byte address match, only within the direct upper space
  function automatic logic hitsByte(input logic [7:0] a,
                                    input logic [7:0] reg_addr,
                                    input logic       direct);
    hitsByte = direct && a[7] && (a == reg_addr);
  endfunction

  // Bit address match for bit-addressable bytes
  function automatic logic hitsBit(input logic [7:0] b,
                                   input logic [7:0] reg_addr);
    hitsBit = (b[7:3] == reg_addr[7:3]);
  endfunction

  logic [7:0]  acc_q;
  logic [7:0]  acc_d;
  logic [7:0]  helper_q;
  logic [7:0]  helper_d;
  logic [7:0]  spLow_q;
  logic [7:0]  spLow_d;
  logic [2:0]  spUp_q;
  logic [2:0]  spUp_d;
  logic [7:0]  dpLow_q;
  logic [7:0]  dpLow_d;
  logic [7:0]  dpHigh_q;
  logic [7:0]  dpHigh_d;
  logic [7:0]  dpPage_q;
  logic [7:0]  dpPage_d;
  logic [7:0]  flags_q;
  logic [7:0]  flags_d;
  logic [7:0]  rdData_q;
  logic [7:0]  rdData_d;
  logic        rdHit_q;
  logic        rdHit_d;
  logic        bitRd_q;
  logic        bitRd_d;

  // Byte decode: anything below 80H or indirect never lands here
  wire selAcc    = hitsByte(sfrAddr, CSR_ADDR_OPERAND, sfrDirect);
  wire selHelper = hitsByte(sfrAddr, CSR_ADDR_HELPER, sfrDirect);
  wire selSpLow  = hitsByte(sfrAddr, CSR_ADDR_STACK_LOW, sfrDirect);
  wire selSpUp   = hitsByte(sfrAddr, CSR_ADDR_STACK_UPPER, sfrDirect);
  wire selDpLow  = hitsByte(sfrAddr, CSR_ADDR_DATA_POINTER_WORD_LOW, sfrDirect);
  wire selDpHigh = hitsByte(sfrAddr, CSR_ADDR_DATA_POINTER_WORD_HIGH, sfrDirect);
  wire selDpPage = hitsByte(sfrAddr, CSR_ADDR_DATA_POINTER_WORD_PAGE, sfrDirect);
  wire selFlags  = hitsByte(sfrAddr, CSR_ADDR_FLAGS, sfrDirect);

  wire anySel = selAcc | selHelper | selSpLow | selSpUp | selDpLow |
                selDpHigh | selDpPage | selFlags;

  // Bit decode covers the flags word, operand and helper bytes
  wire bitAcc    = hitsBit(bitAddr, CSR_ADDR_OPERAND);
  wire bitHelper = hitsBit(bitAddr, CSR_ADDR_HELPER);
  wire bitFlags  = hitsBit(bitAddr, CSR_ADDR_FLAGS);
  wire [2:0] bitIdx = bitAddr[2:0];
  wire [7:0] bitOneHot = 8'h01 << bitIdx;

  // Direct write beats an execution result in the same cycle
  wire [7:0] accPre = accLoadEn ? accLoadData : acc_q;
  wire [7:0] accBit = (bitWrEn && bitAcc) ?
                      ((accPre & ~bitOneHot) |
                       ({8{bitWrVal}} & bitOneHot)) : accPre;
  assign acc_d = (sfrWrEn && selAcc) ? sfrWrData : accBit;

  // Helper byte: multiply/divide result port or plain scratch
  wire [7:0] helperPre = helperLoadEn ? helperLoadData : helper_q;
  wire [7:0] helperBit = (bitWrEn && bitHelper) ?
                         ((helperPre & ~bitOneHot) |
                          ({8{bitWrVal}} & bitOneHot)) : helperPre;
  assign helper_d = (sfrWrEn && selHelper) ? sfrWrData : helperBit;

  // Stack: 11-bit when extended, else wraps within the low byte
  wire [10:0] spFull  = {spUp_q, spLow_q};
  wire [10:0] spPlus  = spFull + 11'h001;
  wire [10:0] spMinus = spFull - 11'h001;
  wire [10:0] spStep  = pushEn ? spPlus : spMinus;
  wire        spMove  = pushEn ^ popEn;
  wire [10:0] spNext  = extStackEn ? spStep :
                        {spUp_q, spStep[7:0]};

  // Increment takes effect before the pushed byte is stored
  wire [10:0] spAfter = spMove ? spNext : spFull;

  assign spLow_d = (sfrWrEn && selSpLow) ? sfrWrData : spAfter[7:0];
  assign spUp_d  = (sfrWrEn && selSpUp) ?
                   sfrWrData[CSR_STACK_EXT-1:0] :
                   spAfter[CSR_STACK_BITS-1:8];

  // Pointer: full 24-bit increment, bytes still written singly
  wire [23:0] dpFull = {dpPage_q, dpHigh_q, dpLow_q};
  wire [23:0] dpInc  = dpFull + 24'h000001;
  wire [23:0] dpNext = dptrIncEn ? dpInc : dpFull;

  assign dpLow_d  = (sfrWrEn && selDpLow)  ? sfrWrData : dpNext[7:0];
  assign dpHigh_d = (sfrWrEn && selDpHigh) ? sfrWrData : dpNext[15:8];
  assign dpPage_d = (sfrWrEn && selDpPage) ? sfrWrData : dpNext[23:16];

  // Flags: per-bit merge of results, bit writes and byte writes
  logic [7:0] flagsMerged;
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_flag
      wire fromExec = flagLoadMask[gi] ? flagLoadData[gi] : flags_q[gi];
      wire fromBit  = (bitWrEn && bitFlags && bitIdx == gi) ?
                      bitWrVal : fromExec;
      assign flagsMerged[gi] = (sfrWrEn && selFlags) ?
                               sfrWrData[gi] : fromBit;
    end
  endgenerate

  // Parity follows the operand value that is about to be stored
  assign flags_d = {flagsMerged[7:1], ^acc_d};

  // Read path, reserved stack bits read as zero
  wire [7:0] spUpRead = {{(8-CSR_STACK_EXT){1'b0}}, spUp_q};

  always_comb begin
    rdData_d = CSR_RD_UNMAPPED;
    unique case (1'b1)
      selAcc:    rdData_d = acc_q;
      selHelper: rdData_d = helper_q;
      selSpLow:  rdData_d = spLow_q;
      selSpUp:   rdData_d = spUpRead;
      selDpLow:  rdData_d = dpLow_q;
      selDpHigh: rdData_d = dpHigh_q;
      selDpPage: rdData_d = dpPage_q;
      selFlags:  rdData_d = flags_q;
      default:   rdData_d = CSR_RD_UNMAPPED;
    endcase
    if (!sfrRdEn) begin
      rdData_d = rdData_q;
    end
  end

  assign rdHit_d = sfrRdEn ? anySel : rdHit_q;

  // Bit read from one of the bit-addressable bytes
  wire bitSrc = bitFlags  ? flags_q[bitIdx] :
                bitAcc    ? acc_q[bitIdx] :
                bitHelper ? helper_q[bitIdx] : 1'b0;
  assign bitRd_d = bitRdEn ? bitSrc : bitRd_q;

  // One block per register keeps each reset value beside its flop
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      acc_q <= CSR_RST_OPERAND;
    end else begin
      acc_q <= acc_d;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      helper_q <= CSR_RST_HELPER;
    end else begin
      helper_q <= helper_d;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      spLow_q <= CSR_RST_STACK_LOW;
    end else begin
      spLow_q <= spLow_d;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      spUp_q <= CSR_RST_STACK_UPPER[CSR_STACK_EXT-1:0];
    end else begin
      spUp_q <= spUp_d;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      dpLow_q <= CSR_RST_DATA_POINTER_WORD;
    end else begin
      dpLow_q <= dpLow_d;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      dpHigh_q <= CSR_RST_DATA_POINTER_WORD;
    end else begin
      dpHigh_q <= dpHigh_d;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      dpPage_q <= CSR_RST_DATA_POINTER_WORD;
    end else begin
      dpPage_q <= dpPage_d;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      flags_q <= CSR_RST_FLAGS;
    end else begin
      flags_q <= flags_d;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rdData_q <= CSR_RD_UNMAPPED;
    end else begin
      rdData_q <= rdData_d;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rdHit_q <= 1'b0;
    end else begin
      rdHit_q <= rdHit_d;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      bitRd_q <= 1'b0;
    end else begin
      bitRd_q <= bitRd_d;
    end
  end

  assign sfrRdData = rdData_q;
  assign sfrRdHit  = rdHit_q;
  assign bitRdVal  = bitRd_q;

  assign mainOperandReg  = acc_q;
  assign helperReg       = helper_q;
  // Shows the slot the last push wrote, one cycle after the push
  assign stackAddr       = spFull;
  assign dataPointerFull = dpFull;
  assign dataPointerWord = {dpHigh_q, dpLow_q};

  // Bank number straight from the two select bits
  assign bankSelect  = {flags_q[CSR_FLAG_BANKHI],
                        flags_q[CSR_FLAG_BANKLO]};
  // Eight working registers per bank, banks packed from address 0
  assign workRegBase = {bankSelect,
                        {CSR_BANK_REGS_LOG2{1'b0}}};

  assign carryFlag      = flags_q[CSR_FLAG_CARRY];
  assign halfCarryFlag  = flags_q[CSR_FLAG_HALF];
  assign userFlagZero   = flags_q[CSR_FLAG_USER0];
  assign arithRangeFlag = flags_q[CSR_FLAG_RANGE];
  assign userFlagOne    = flags_q[CSR_FLAG_USER1];
  assign parityFlag     = flags_q[CSR_FLAG_PARITY];

endmodule // csr_core_regs

`default_nettype wire

// *** testbench/csr_core_regs_asserts.sv ***
`timescale 1ns/1ps
`default_nettype none
module csr_core_regs_asserts (
  input wire logic        clk,
  input wire logic        reset_n,
  input wire logic        sfrDirect,
  input wire logic        sfrWrEn,
  input wire logic        bitWrEn,
  input wire logic        accLoadEn,
  input wire logic [7:0]  accLoadData,
  input wire logic        helperLoadEn,
  input wire logic [7:0]  helperLoadData,
  input wire logic        pushEn,
  input wire logic        popEn,
  input wire logic        extStackEn,
  input wire logic        dptrIncEn,
  input wire logic [7:0]  mainOperandReg,
  input wire logic [7:0]  helperReg,
  input wire logic [10:0] stackAddr,
  input wire logic [23:0] dataPointerFull,
  input wire logic [15:0] dataPointerWord,
  input wire logic [1:0]  bankSelect,
  input wire logic [4:0]  workRegBase,
  input wire logic        parityFlag
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // Byte writes outrank these updates, so they are kept out
  sequence pushOnly;
    pushEn && !popEn && extStackEn && !sfrWrEn;
  endsequence
  sequence accOnly;
    accLoadEn && !sfrWrEn && !bitWrEn;
  endsequence
  chk_parity_even:
    assert property (parityFlag == ^mainOperandReg) else $error("parity");
  chk_push_pre_inc:
    assert property (pushOnly |=> stackAddr == $past(stackAddr) + 11'h001)
      else $error("push increment");
  chk_data_pointer_word_carry:
    assert property (dptrIncEn && !sfrWrEn
      |=> dataPointerFull == $past(dataPointerFull) + 24'h000001)
      else $error("pointer increment");
  chk_bank_base:
    assert property (workRegBase == {bankSelect, 3'h0}) else $error("bank");
  chk_word_view:
    assert property (dataPointerWord == dataPointerFull[15:0])
      else $error("pointer word");
  chk_acc_load:
    assert property (accOnly |=> mainOperandReg == $past(accLoadData))
      else $error("operand load");
  chk_helper_load:
    assert property (helperLoadEn && !sfrWrEn && !bitWrEn
      |=> helperReg == $past(helperLoadData)) else $error("helper load");
  chk_indirect_ignored:
    assert property (sfrWrEn && !sfrDirect && !accLoadEn && !bitWrEn
      |=> $stable(mainOperandReg)) else $error("indirect write");
endmodule // csr_core_regs_asserts
bind csr_core_regs csr_core_regs_asserts i_chk (.*);
`default_nettype wire

// *** testbench/csr_dp_stack.sv ***
`timescale 1ns/1ps
`default_nettype none
module csr_dp_stack (
  input  wire logic        clk,
  input  wire logic        pushEn,
  input  wire logic [10:0] stackAddr,
  output logic      [10:0] lastPushAddr
);
  logic pending = 1'b0;
  // Byte lands one cycle later, at the already incremented address
  always @(posedge clk) begin
    pending <= pushEn;
    if (pending) begin
      lastPushAddr <= stackAddr;
    end
  end
endmodule // csr_dp_stack
`default_nettype wire

// *** testbench/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import csr_pkg::*;
  logic        clk = 1'b0, reset_n = 1'b0, sfrDirect = 1'b1;
  logic        sfrWrEn = 1'b0, sfrRdEn = 1'b0, bitWrEn = 1'b0;
  logic        bitWrVal = 1'b0, bitRdEn = 1'b0, accLoadEn = 1'b0;
  logic        helperLoadEn = 1'b0, pushEn = 1'b0, popEn = 1'b0;
  logic        extStackEn = 1'b1, dptrIncEn = 1'b0;
  logic [7:0]  sfrAddr = 8'h00, sfrWrData = 8'h00, bitAddr = 8'h00;
  logic [7:0]  accLoadData = 8'h00, helperLoadData = 8'h00;
  logic [7:0]  flagLoadMask = 8'h00, flagLoadData = 8'h00;
  logic [7:0]  sfrRdData, mainOperandReg, helperReg;
  logic [10:0] stackAddr, lastPushAddr;
  logic [23:0] dataPointerFull;
  logic [15:0] dataPointerWord;
  logic [4:0]  workRegBase;
  logic [1:0]  bankSelect;
  logic        sfrRdHit, bitRdVal, carryFlag, halfCarryFlag, userFlagZero;
  logic        arithRangeFlag, userFlagOne, parityFlag;
  int          n_errors = 0, samples_checked = 0;

  always #25 clk = ~clk;
  csr_core_regs i_csr_core_regs (.*);
  csr_dp_stack i_csr_dp_stack (.clk(clk), .pushEn(pushEn),
    .stackAddr(stackAddr), .lastPushAddr(lastPushAddr));

  task automatic check(input string nm, input logic [23:0] exp, got);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, d, input logic dir = 1'b1);
    @(posedge clk);
    sfrAddr <= a;
    sfrWrData <= d;
    sfrDirect <= dir;
    sfrWrEn <= 1'b1;
    @(posedge clk);
    sfrWrEn <= 1'b0;
    sfrDirect <= 1'b1;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, exp);
    @(posedge clk);
    sfrAddr <= a;
    sfrRdEn <= 1'b1;
    @(posedge clk);
    sfrRdEn <= 1'b0;
    #1;
    check("read data", {16'h0, exp}, {16'h0, sfrRdData});
  endtask
  // One-cycle strobes: bit 0 push, 1 pop, 2 pointer step, 3 operand,
  // 4 helper, 5 bit write, 6 bit read; effect shows after the 2nd edge
  task automatic pulse(input logic [6:0] m);
    @(posedge clk);
    {bitRdEn, bitWrEn, helperLoadEn, accLoadEn, dptrIncEn, popEn,
     pushEn} <= m;
    @(posedge clk);
    {bitRdEn, bitWrEn, helperLoadEn, accLoadEn, dptrIncEn, popEn,
     pushEn} <= 7'h00;
    #1;
  endtask
  task automatic t_reset();
    check("stack", 24'h7, stackAddr);
    rd(CSR_ADDR_FLAGS, 8'h00);
  endtask
  task automatic t_banks();
    for (int b = 0; b < 4; b++) begin
      wr(CSR_ADDR_FLAGS, 8'(b << 3));
      check("bank", 24'(b), bankSelect);
      check("base", 24'(b * 8), workRegBase);
    end
    @(posedge clk);
    bitAddr <= 8'hd7;
    bitWrVal <= 1'b1;
    pulse(7'h20);
    check("carry", 24'h1, carryFlag);
    rd(CSR_ADDR_FLAGS, 8'h98);
    @(posedge clk);
    flagLoadMask <= 8'hff;
    flagLoadData <= 8'h24;
    @(posedge clk);
    flagLoadMask <= 8'h00;
    #1;
    check("user zero", 24'h1, userFlagZero);
    check("half carry", 24'h0, halfCarryFlag);
    check("range", 24'h1, arithRangeFlag);
    check("user one", 24'h0, userFlagOne);
    @(posedge clk);
    bitAddr <= 8'hd5;
    pulse(7'h40);
    check("bit read", 24'h1, bitRdVal);
  endtask
  task automatic t_stack();
    pulse(7'h01);
    check("push", 24'h8, stackAddr);
    @(posedge clk);
    #1;
    check("push slot", 24'h8, lastPushAddr);
    wr(CSR_ADDR_STACK_UPPER, 8'hf8);
    wr(CSR_ADDR_STACK_LOW, 8'hff);
    pulse(7'h01);
    check("ext push", 24'h100, stackAddr);
    rd(CSR_ADDR_STACK_UPPER, 8'h01);
    @(posedge clk);
    extStackEn <= 1'b0;
    pulse(7'h02);
    check("short pop", 24'h1ff, stackAddr);
    @(posedge clk);
    extStackEn <= 1'b1;
  endtask
  task automatic t_data_pointer_word();
    wr(CSR_ADDR_DATA_POINTER_WORD_PAGE, 8'h00);
    wr(CSR_ADDR_DATA_POINTER_WORD_HIGH, 8'hff);
    wr(CSR_ADDR_DATA_POINTER_WORD_LOW, 8'hff);
    pulse(7'h04);
    check("pointer", 24'h010000, dataPointerFull);
    check("word", 24'h0, dataPointerWord);
    rd(CSR_ADDR_DATA_POINTER_WORD_PAGE, 8'h01);
  endtask
  task automatic t_operand();
    @(posedge clk);
    accLoadData <= 8'h07;
    helperLoadData <= 8'h5a;
    pulse(7'h08);
    check("operand", 24'h07, mainOperandReg);
    check("parity", 24'h1, parityFlag);
    pulse(7'h10);
    check("helper", 24'h5a, helperReg);
    wr(CSR_ADDR_OPERAND, 8'hff, 1'b0);
    check("indirect", 24'h07, mainOperandReg);
    rd(CSR_ADDR_OPERAND, 8'h07);
    check("hit", 24'h1, sfrRdHit);
    wr(CSR_ADDR_HELPER, 8'ha5);
    rd(CSR_ADDR_HELPER, 8'ha5);
    rd(8'h85, 8'h00);
    check("miss", 24'h0, sfrRdHit);
  endtask
  task automatic complete_run();
    $display("Checked %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    #1;
    t_reset();
    t_banks();
    t_stack();
    t_data_pointer_word();
    t_operand();
    complete_run();
  end
  // Hang guard
  initial begin
    repeat (5000) @(posedge clk);
    n_errors++;
    complete_run();
  end
endmodule // tb_top
`default_nettype wire
